// file: src/bwc_consts.svh
// Register offsets, reset values and field positions of the wait config block.
`ifndef BWC_CONSTS_SVH
`define BWC_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BWC_OFS_AREA_WAIT     12'h000
`define BWC_OFS_DMA_CYCLES    12'h004
`define BWC_OFS_STATUS        12'h008
`define BWC_RST_AREA_WAIT     16'hffff
`define BWC_RST_DMA_CYCLES    16'h000f
`define BWC_AREA_FIELD_W      4
`define BWC_NUM_AREAS         4
`define BWC_REG_W             16

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BWC_STAT_BUSY_BIT     0
`define BWC_STAT_AREA_LSB     1
`define BWC_STAT_WAITING_BIT  3

`endif

// file: src/bwc_pkg.sv
// Types shared by the wait config block.
`default_nettype none
package bwc_pkg;
   typedef enum logic [1:0] {BWC_IDLE, BWC_WAIT, BWC_EXT, BWC_DONE} bwc_state_type;
endpackage : bwc_pkg
`default_nettype wire

// file: src/bwc_wait_seq.sv
// Access sequencer that inserts programmed and externally requested wait cycles.
`default_nettype none
`include "bwc_consts.svh"
module bwc_wait_seq
   import bwc_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // Access request and programmed count.
   input  wire logic        i_start,
   input  wire logic [3:0]  i_count,
   input  wire logic        i_ext_wait,
   // Sequencer status.
   output logic             o_busy,
   output logic             o_done,
   output logic             o_waiting
);

   typedef struct packed {
      bwc_state_type state;
      logic [3:0]    cnt;
      logic          done;
      logic          busy;
      logic          waiting;
   } bwc_seq_type;

   bwc_seq_type s_r, s_nxt;

   // ----------------------------------------------------------------
   // Wait sequencing
   // ----------------------------------------------------------------
   // A zero count skips straight to completion and never looks at the wait input.
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      case (s_r.state)
         BWC_IDLE:
         begin
            if (i_start)
            begin
               s_nxt.cnt = i_count;
               if (i_count == 4'h0)
               begin
                  s_nxt.state = BWC_DONE;
                  s_nxt.done  = 1'b1;
               end
               else
               begin
                  s_nxt.state = BWC_WAIT;
               end
            end
         end
         BWC_WAIT:
         begin
            s_nxt.cnt = s_r.cnt - 4'h1;
            if (s_r.cnt == 4'h1)
            begin
               if (i_ext_wait)
               begin
                  s_nxt.state = BWC_EXT;
               end
               else
               begin
                  s_nxt.state = BWC_DONE;
                  s_nxt.done  = 1'b1;
               end
            end
         end
         BWC_EXT:
         begin
            // Extension lasts as long as the external party holds the input.
            if (!i_ext_wait)
            begin
               s_nxt.state = BWC_DONE;
               s_nxt.done  = 1'b1;
            end
         end
         BWC_DONE:
         begin
            s_nxt.state = BWC_IDLE;
         end
         default:
         begin
            s_nxt.state = BWC_IDLE;
         end
      endcase
      // Status flags are registered so that the outputs come from flops.
      s_nxt.busy    = (s_nxt.state != BWC_IDLE);
      s_nxt.waiting = (s_nxt.state == BWC_EXT);
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         s_r <= '{state: BWC_IDLE, cnt: 4'h0, done: 1'b0, busy: 1'b0, waiting: 1'b0};
      else
         s_r <= s_nxt;
   end

   // Outputs come straight from state flops.
   assign o_busy    = s_r.busy;
   assign o_done    = s_r.done;
   assign o_waiting = s_r.waiting;

endmodule : bwc_wait_seq
`default_nettype wire

// file: src/bwc_top.sv
// APB register bank for per-area wait counts and DMA access cycles, with wait sequencer.
//
// Operation
// - Area wait register is 16-bit read/write, four 0-15 wait counts.
// - Power-on reset loads the area wait register with all ones.
// - Manual reset and standby leave both wait registers unchanged.
// - Bits 15:12 hold the area three wait count.
// - Bits 11:8 hold the area two wait count.
// - Bits 7:4 hold the area one wait count.
// - Bits 3:0 hold the area zero wait count.
// - Count zero inserts no waits and ignores the external wait input.
// - Nonzero count N inserts N waits and honours the external wait.
// - DMA single-address cycle register is 16-bit read/write.
// - Power-on reset sets the DMA cycle register to 000F.
//
// Notes for the next engineer.
// Every APB transfer completes with no wait state: pready is a
// one-cycle pulse in the first access-phase cycle.
// Read data and the error flag are latched at the setup edge,
// so they stand while pready is high.
// Writes land at the edge where pready is sampled high, which is
// the edge at which the master ends the transfer.
// Only the low half of a word is stored; the upper half reads 0.
// Manual reset and standby are ports but are not decoded: both
// wait registers must survive them.
// The wait pin is asynchronous and passes two flops; the price is
// two cycles before an extension is seen at the end of a count.
// A zero count skips the wait pin, so a device that asserts it on
// such an area is never waited for.
// The DMA cycle register is only stored and passed on.
`default_nettype none
`include "bwc_consts.svh"
module bwc_top
   import bwc_pkg::*;
(
   // Clock and power-on reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // Manual reset and standby requests, held off the register bank.
   input  wire logic        i_manual_rst,
   input  wire logic        i_standby,
   // APB slave.
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // External access request and wait pin.
   input  wire logic        i_access_req,
   input  wire logic [1:0]  i_access_area,
   input  wire logic        i_ext_wait_pin,
   // Settings and access status towards the bus controller.
   output logic [15:0]      o_dma_cycles,
   output logic             o_access_done,
   output logic             o_access_busy
);

   // All checks below run on the reference clock; all but the two power-on checks sleep in reset.
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] area_wait;
      logic [15:0] dma_cycles;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [1:0]  area;
      logic        wait_s1;
      logic        wait_s2;
      logic        start;
   } bwc_top_type;

   bwc_top_type s_r, s_nxt;

   logic seq_busy;
   logic seq_done;
   logic seq_waiting;

   // Pick one area's four-bit count out of the register.
   function automatic logic [3:0] area_count(input logic [15:0] r, input logic [1:0] a);
      area_count = r[a*`BWC_AREA_FIELD_W +: `BWC_AREA_FIELD_W];
   endfunction : area_count

   // Setup phase of APB, sampled once per transfer.
   logic apb_setup;
   assign apb_setup = i_psel && !i_penable;

   // Access phase with pready high: the edge at which a transfer ends.
   logic apb_access;
   assign apb_access = i_psel && i_penable && s_r.pready;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Read data registered at the setup edge keeps the read mux off the critical path with no wait state.
   always_comb
   begin
      s_nxt         = s_r;
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.start   = 1'b0;
      // The pin is foreign to this clock, so it passes two flops first.
      s_nxt.wait_s1 = i_ext_wait_pin;
      s_nxt.wait_s2 = s_r.wait_s1;
      if (apb_setup)
      begin
         s_nxt.pready = 1'b1;
         case (i_paddr)
            `BWC_OFS_AREA_WAIT:
            begin
               s_nxt.prdata = {16'h0000, s_r.area_wait};
            end
            `BWC_OFS_DMA_CYCLES:
            begin
               s_nxt.prdata = {16'h0000, s_r.dma_cycles};
            end
            `BWC_OFS_STATUS:
            begin
               s_nxt.pslverr = i_pwrite;
               s_nxt.prdata  = {28'h0000000, seq_waiting, s_r.area, seq_busy};
            end
            default:
            begin
               s_nxt.pslverr = 1'b1;
               s_nxt.prdata  = 32'h00000000;
            end
         endcase
      end
      // Writes land at the edge where pready is seen high, never at setup.
      if (apb_access && i_pwrite)
      begin
         case (i_paddr)
            `BWC_OFS_AREA_WAIT:
            begin
               s_nxt.area_wait = i_pwdata[15:0];
            end
            `BWC_OFS_DMA_CYCLES:
            begin
               s_nxt.dma_cycles = i_pwdata[15:0];
            end
            default:
            begin
               s_nxt.area_wait = s_r.area_wait;
            end
         endcase
      end
      // Manual reset and standby are deliberately not decoded here.
      if (i_access_req && !seq_busy && !s_r.start)
      begin
         s_nxt.start = 1'b1;
         s_nxt.area  = i_access_area;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Only the power-on reset loads the bank with its reset values.
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_r            <= '0;
         s_r.area_wait  <= `BWC_RST_AREA_WAIT;
         s_r.dma_cycles <= `BWC_RST_DMA_CYCLES;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Wait sequencer
   // ----------------------------------------------------------------
   bwc_wait_seq u_seq (
      .i_ref_clk  (i_ref_clk),
      .i_rst      (i_rst),
      .i_start    (s_r.start),
      .i_count    (area_count(s_r.area_wait, s_r.area)),
      .i_ext_wait (s_r.wait_s2),
      .o_busy     (seq_busy),
      .o_done     (seq_done),
      .o_waiting  (seq_waiting)
   );

   assign o_prdata      = s_r.prdata;
   assign o_pready      = s_r.pready;
   assign o_pslverr     = s_r.pslverr;
   assign o_dma_cycles  = s_r.dma_cycles;
   assign o_access_done = seq_done;
   assign o_access_busy = seq_busy;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Area write lands at the pready edge.
   a_area_write: assert property (
      apb_access && i_pwrite && i_paddr == `BWC_OFS_AREA_WAIT
      |=> s_r.area_wait == $past(i_pwdata[15:0]))
      else $error("area wait write lost");
   // DMA cycle write lands at the pready edge.
   a_dma_write: assert property (
      apb_access && i_pwrite && i_paddr == `BWC_OFS_DMA_CYCLES
      |=> o_dma_cycles == $past(i_pwdata[15:0]))
      else $error("dma cycle write lost");
   // Area read returns the stored value.
   a_area_read: assert property (
      apb_setup && !i_pwrite && i_paddr == `BWC_OFS_AREA_WAIT
      |=> o_prdata == {16'h0000, $past(s_r.area_wait)})
      else $error("area wait read wrong");
   // DMA cycle read returns the stored value.
   a_dma_read: assert property (
      apb_setup && !i_pwrite && i_paddr == `BWC_OFS_DMA_CYCLES
      |=> o_prdata == {16'h0000, $past(s_r.dma_cycles)})
      else $error("dma cycle read wrong");
   // Registers are 16 bits, the upper half reads zero.
   a_upper_zero: assert property (
      o_pready |-> o_prdata[31:16] == 16'h0000)
      else $error("upper half not zero");
   // Nothing but a write changes the bank.
   a_bank_hold: assert property (
      !(apb_access && i_pwrite)
      |=> $stable(s_r.area_wait) && $stable(s_r.dma_cycles))
      else $error("bank changed without write");
   // Manual reset and standby leave the bank alone.
   a_standby_hold: assert property (
      (i_manual_rst || i_standby) && !(apb_access && i_pwrite)
      |=> $stable(s_r.area_wait) && $stable(s_r.dma_cycles))
      else $error("bank changed in standby");
   // Power-on values of the area register.
   a_reset_vals: assert property (disable iff (1'b0)
      $fell(i_rst) |-> s_r.area_wait == `BWC_RST_AREA_WAIT)
      else $error("bad power-on area value");
   // Power-on value of the DMA cycle register.
   a_reset_dma: assert property (disable iff (1'b0)
      $fell(i_rst) |-> s_r.dma_cycles == `BWC_RST_DMA_CYCLES)
      else $error("bad power-on dma value");
   // Ready is a single-cycle pulse.
   a_pready_pulse: assert property (
      o_pready |=> !o_pready)
      else $error("pready held too long");
   // Every setup is answered in the next cycle.
   a_pready_time: assert property (
      apb_setup |=> o_pready)
      else $error("pready late");
   // The error flag only comes with ready.
   a_slverr_pair: assert property (
      o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   // Unmapped addresses are refused.
   a_unmapped: assert property (
      apb_setup && i_paddr > `BWC_OFS_STATUS |=> o_pready && o_pslverr)
      else $error("unmapped not flagged");
   // The status word cannot be written.
   a_status_ro: assert property (
      apb_setup && i_pwrite && i_paddr == `BWC_OFS_STATUS |=> o_pslverr)
      else $error("status write not refused");
   // A zero count ends right after the start.
   a_zero_nowait: assert property (
      s_r.start && area_count(s_r.area_wait, s_r.area) == 4'h0 |=> o_access_done)
      else $error("zero count not immediate");
   // Seven waits keep done low for seven cycles.
   a_n_waits: assert property (
      s_r.start && area_count(s_r.area_wait, s_r.area) == 4'h7
      |=> !o_access_done [*7])
      else $error("waits too short");
   // Area three uses bits 15 to 12.
   a_field_three: assert property (
      s_r.start && s_r.area == 2'h3 && s_r.area_wait[15:12] == 4'h7
      |=> !o_access_done [*7])
      else $error("area three field wrong");
   // Area two uses bits 11 to 8.
   a_field_two: assert property (
      s_r.start && s_r.area == 2'h2 && s_r.area_wait[11:8] == 4'hf
      |=> !o_access_done [*8])
      else $error("area two field wrong");
   // Area one uses bits 7 to 4.
   a_field_one: assert property (
      s_r.start && s_r.area == 2'h1 && s_r.area_wait[7:4] == 4'h0
      |=> o_access_done)
      else $error("area one field wrong");
   // Area zero uses bits 3 to 0.
   a_field_zero: assert property (
      s_r.start && s_r.area == 2'h0 && s_r.area_wait[3:0] == 4'h1
      |=> !o_access_done)
      else $error("area zero field wrong");
   // Done follows the start at once exactly for a zero field.
   for (genvar g = 0; g < `BWC_NUM_AREAS; g++)
   begin : g_area_chk
      a_area_zero: assert property (
         s_r.start && s_r.area == 2'(g) |=> o_access_done ==
         ($past(s_r.area_wait[g*`BWC_AREA_FIELD_W +: `BWC_AREA_FIELD_W]) == 4'h0))
         else $error("per area timing wrong");
   end
   // A held pin keeps the access open.
   a_ext_hold: assert property (
      seq_waiting && s_r.wait_s2 |=> !o_access_done)
      else $error("ended during external wait");
   // The second sync flop only follows the first.
   a_sync_order: assert property (
      s_r.wait_s2 == $past(s_r.wait_s1))
      else $error("wait sync out of order");
   // Extension is part of a running access.
   a_ext_busy: assert property (
      seq_waiting |-> o_access_busy)
      else $error("waiting while idle");
   // Done is a single-cycle pulse.
   a_done_pulse: assert property (
      o_access_done |=> !o_access_done)
      else $error("done held too long");
   // Done is raised inside a running access.
   a_done_busy: assert property (
      o_access_done |-> o_access_busy)
      else $error("done while idle");
   // A request is only taken while idle.
   a_start_idle: assert property (
      s_r.start |-> !o_access_busy)
      else $error("start while busy");

   // Main scenarios that the bench must reach.
   c_ext_wait:  cover property (seq_waiting);
   c_zero:      cover property (
      s_r.start && area_count(s_r.area_wait, s_r.area) == 4'h0);
   c_write:     cover property (
      apb_access && i_pwrite && i_paddr == `BWC_OFS_AREA_WAIT);
   c_dma_write: cover property (
      apb_access && i_pwrite && i_paddr == `BWC_OFS_DMA_CYCLES);
   c_unmapped:  cover property (apb_setup && i_paddr > `BWC_OFS_STATUS);

endmodule : bwc_top
`default_nettype wire

// file: test/bwc_ext_dev.sv
// Model of an external device that holds the wait pin during an access.
`default_nettype none
module bwc_ext_dev
(
   // Clock and access status.
   input  wire logic       i_ref_clk,
   input  wire logic       i_busy,
   // Number of cycles to hold the pin from the start of each access, zero for none.
   input  wire logic [4:0] i_hold,
   // Wait request towards the device.
   output logic            o_wait
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0] age_r = 5'h00;

   // ----------------------------------------------------------------
   // Wait pin
   // ----------------------------------------------------------------
   // Count the cycles of the running access; the count restarts between accesses.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_busy)
         age_r <= 5'h00;
      else if (age_r != 5'h1f)
         age_r <= age_r + 5'h01;
   end

   // The pin is driven at all times, so it never floats between accesses.
   assign o_wait = i_busy && (age_r < i_hold);
endmodule : bwc_ext_dev
`default_nettype wire

// file: test/tb_bwc_top.sv
// Self-checking testbench for the wait config register bank and sequencer.
`default_nettype none
`include "bwc_consts.svh"
module tb_bwc_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        i_ref_clk      = 1'b0;
   logic        i_rst          = 1'b1;
   logic        i_manual_rst   = 1'b0;
   logic        i_standby      = 1'b0;
   logic        i_psel         = 1'b0;
   logic        i_penable      = 1'b0;
   logic        i_pwrite       = 1'b0;
   logic [11:0] i_paddr        = 12'h000;
   logic [31:0] i_pwdata       = 32'h0000_0000;
   logic        i_access_req   = 1'b0;
   logic [1:0]  i_access_area  = 2'h0;
   logic [4:0]  hold           = 5'h00;
   logic [31:0] o_prdata;
   logic        o_pready;
   logic        o_pslverr;
   logic        ext_wait;
   logic [15:0] o_dma_cycles;
   logic        o_access_done;
   logic        o_access_busy;
   logic [31:0] rd;
   logic        err;
   int          lat;
   int          num_errors     = 0;
   int          n_checks       = 0;
   logic [3:0]  cnt [4]        = '{4'h1, 4'h0, 4'hf, 4'h7};

   // ----------------------------------------------------------------
   // Clock, design and far side
   // ----------------------------------------------------------------
   // A 40 ns period gives the 25 MHz reference clock.
   always #20 i_ref_clk = ~i_ref_clk;

   bwc_top uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_manual_rst(i_manual_rst),
      .i_standby(i_standby), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_access_req(i_access_req), .i_access_area(i_access_area),
      .i_ext_wait_pin(ext_wait), .o_dma_cycles(o_dma_cycles),
      .o_access_done(o_access_done), .o_access_busy(o_access_busy));

   bwc_ext_dev dev (.i_ref_clk(i_ref_clk), .i_busy(o_access_busy), .i_hold(hold),
      .o_wait(ext_wait));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compare one value and count the outcome.
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Print the counts and the verdict, then stop.
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // One APB transfer; the request stands until pready is seen at a rising edge.
   task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n;
      @(posedge i_ref_clk);
      i_psel   <= 1'b1;
      i_pwrite <= wr;
      i_paddr  <= addr;
      i_pwdata <= wd;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      n = 0;
      // Ready is a flop, so its value before an edge is what that edge sees.
      do
      begin
         @(negedge i_ref_clk);
         n++;
      end
      while (o_pready !== 1'b1 && n < 20);
      rd  = o_prdata;
      err = o_pslverr;
      @(posedge i_ref_clk);
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20)
      begin
         num_errors++;
         end_of_test();
      end
   endtask : apb

   // One access to an area; lat gets the edges from the taken request to done.
   task access(input logic [1:0] area);
      int n;
      @(posedge i_ref_clk);
      i_access_req  <= 1'b1;
      i_access_area <= area;
      @(posedge i_ref_clk);
      i_access_req <= 1'b0;
      n = 0;
      do
      begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      while (o_access_done !== 1'b1 && n < 60);
      lat = n;
      if (n >= 60)
      begin
         num_errors++;
         end_of_test();
      end
      // Idle cycles let busy fall so the next request is not ignored.
      repeat (3) @(posedge i_ref_clk);
   endtask : access

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      chk({16'h0000, o_dma_cycles}, 32'h0000_000f);
      apb(1'b0, `BWC_OFS_AREA_WAIT, 32'h0);
      chk(rd, 32'h0000_ffff);
      apb(1'b0, `BWC_OFS_DMA_CYCLES, 32'h0);
      chk(rd, 32'h0000_000f);
      // Upper half of the written word must be dropped.
      apb(1'b1, `BWC_OFS_AREA_WAIT, 32'hdead_7f01);
      apb(1'b1, `BWC_OFS_DMA_CYCLES, 32'hbeef_a5c3);
      apb(1'b0, `BWC_OFS_AREA_WAIT, 32'h0);
      chk(rd, 32'h0000_7f01);
      apb(1'b0, `BWC_OFS_DMA_CYCLES, 32'h0);
      chk(rd, 32'h0000_a5c3);
      chk({16'h0000, o_dma_cycles}, 32'h0000_a5c3);
      // Manual reset and standby must leave both settings alone.
      i_manual_rst <= 1'b1;
      i_standby    <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_manual_rst <= 1'b0;
      i_standby    <= 1'b0;
      apb(1'b0, `BWC_OFS_AREA_WAIT, 32'h0);
      chk(rd, 32'h0000_7f01);
      apb(1'b0, `BWC_OFS_DMA_CYCLES, 32'h0);
      chk(rd, 32'h0000_a5c3);
      // Unmapped and read-only places are refused.
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `BWC_OFS_STATUS, 32'hffff_ffff);
      chk({31'h0, err}, 32'h1);
      // Each area uses its own field: counts 1, 0, 15 and 7.
      for (int i = 0; i < 4; i++)
      begin
         access(2'(i));
         chk(32'(lat), 32'(cnt[i]) + 32'd1);
      end
      // External wait held for up to the first 20 cycles of every access.
      hold <= 5'd20;
      access(2'h1);
      chk(32'(lat), 32'd1);
      access(2'h2);
      chk({31'h0, lat > 17}, 32'h1);
      chk({31'h0, lat < 40}, 32'h1);
      end_of_test();
   end
endmodule : tb_bwc_top
`default_nettype wire
